// ===== src/ers_pkg.sv
// package for the receive frame status block: register map, field layout, types
package ers_pkg;
  localparam logic [7:0] ERS_STATUS_OFS = 8'h00;
  localparam logic [7:0] ERS_CTRL_OFS = 8'h04;
  localparam logic [7:0] ERS_COUNT_OFS = 8'h08;
  localparam int ERS_CF_BIT = 25;
  localparam int ERS_CE_BIT = 21;
  localparam int ERS_EB_BIT = 20;
  localparam int ERS_ME_BIT = 19;
  localparam int ERS_FT_BIT = 18;
  localparam int ERS_LC_BIT = 17;
  localparam int ERS_OL_BIT = 16;
  localparam int ERS_RF_BIT = 15;
  localparam int ERS_WT_BIT = 14;
  localparam int ERS_FC_BIT = 13;
  localparam logic [31:0] ERS_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ERS_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] ERS_TYPE_MIN = 16'h0600;
  localparam logic [15:0] ERS_VLAN_TPID = 16'h8100;
  localparam logic [15:0] ERS_CTRL_TYPE = 16'h8808;
  localparam logic [11:0] ERS_COLL_WIN = 12'h040;
  localparam logic [11:0] ERS_MAX_UNTAG = 12'h5ee;
  localparam logic [11:0] ERS_MAX_TAG = 12'h5f2;
  localparam logic [11:0] ERS_LEN_LIMIT = 12'h7ff;
  localparam logic [7:0] ERS_SFD = 8'hd5;
  // remainder left in the lsb-first register once the fcs has been shifted through it
  localparam logic [31:0] ERS_CRC_RESIDUE = 32'hdebb20e3;
  // mii receive pins, sampled together
  typedef struct packed {
    logic dv;
    logic er;
    logic col;
    logic [3:0] d;
  } ers_mii_t;
  // wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ers_wb_req_t;
endpackage

// ===== src/ers_rx_status.sv
// receive frame status evaluation with wishbone register access
// Operation
// RQ1 - set partial-byte flag on odd nibble ending
// RQ2 - partial byte alone does not flag error
// RQ3 - set phy error flag on rx_er in frame
// RQ4 - set type flag when field >= 0x0600
// RQ5 - field at bytes 13-14, or 17-18 tagged
// RQ6 - control frame also sets type flag
// RQ7 - late collision after 64 byte window
// RQ8 - oversize beyond 1518 untagged, 1522 tagged; the code sets it only without crc error, phy error or overflow
// RQ9 - runt when damaged within 64 bytes
// RQ10 - length overflow beyond 2047 bytes
// RQ11 - false carrier flag from phy indication
// RQ12 - status bits 12:11 always zero
// RQ13 - 11-bit byte count without preamble, sfd
// RQ14 - length valid only without overflow flag
// RQ15 - crc error on wrong frame check; the code does not report it for runt or overflow frames
// RQ16 - phy error forces crc error flag
// RQ17 - flags per frame, updated at end
`timescale 1ns/1ps
module ers_rx_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mii_rx_clk_i,
  input wire ers_pkg::ers_mii_t mii_i,
  input wire ers_pkg::ers_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic frame_done_o
);
  import ers_pkg::*;

  // two-stage synchronisers: link clock and pins
  logic [1:0] clk_sync_reg;
  ers_mii_t pin_s1_reg;
  ers_mii_t pin_s2_reg;
  logic clk_prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sync_reg <= 2'b00;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], mii_rx_clk_i};
      pin_s1_reg <= mii_i;
      pin_s2_reg <= pin_s1_reg;
      clk_prev_reg <= clk_sync_reg[1];
    end
  end
  // pins share the clock's two-stage delay, so sampling on the rising edge is aligned
  logic rx_edge;
  assign rx_edge = clk_sync_reg[1] & ~clk_prev_reg;

  typedef enum logic [1:0] {ERS_IDLE, ERS_PREAMBLE, ERS_DATA} ers_state_t;
  ers_state_t state_reg;

  // frame accumulators
  logic nib_hi_reg;
  logic [3:0] nib_lo_reg;
  logic [11:0] frame_byte_counter_reg;
  logic phy_rx_error_flag_reg;
  logic late_collision_flag_reg;
  logic early_coll_reg;
  logic false_carrier_flag_reg;
  logic tagged_reg;
  logic [15:0] tpid_reg;
  logic [15:0] len_type_reg;
  logic [47:0] dst_reg;
  logic [31:0] crc_reg;

  logic [7:0] byte_now;
  logic byte_done;
  logic frame_end;
  assign byte_now = {pin_s2_reg.d, nib_lo_reg};
  assign byte_done = rx_edge && state_reg == ERS_DATA && pin_s2_reg.dv && nib_hi_reg;
  assign frame_end = rx_edge && state_reg == ERS_DATA && !pin_s2_reg.dv;

  // crc over one byte, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
    end
    return r;
  endfunction

  // receive state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ERS_IDLE;
    end else if (rx_edge) begin
      unique case (state_reg)
        ERS_IDLE: begin
          if (pin_s2_reg.dv) begin
            state_reg <= ERS_PREAMBLE;
          end
        end
        ERS_PREAMBLE: begin
          if (!pin_s2_reg.dv) begin
            state_reg <= ERS_IDLE;
          end else if (pin_s2_reg.d == ERS_SFD[7:4] && nib_lo_reg == ERS_SFD[3:0]) begin
            state_reg <= ERS_DATA;
          end
        end
        ERS_DATA: begin
          if (!pin_s2_reg.dv) begin
            state_reg <= ERS_IDLE;
          end
        end
      endcase
    end
  end

  // nibble pairing: low nibble first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nib_hi_reg <= 1'b0;
      nib_lo_reg <= 4'h0;
    end else if (rx_edge) begin
      if (state_reg == ERS_PREAMBLE) begin
        nib_lo_reg <= pin_s2_reg.d;
        nib_hi_reg <= 1'b0;
      end else if (state_reg == ERS_DATA && pin_s2_reg.dv) begin
        nib_hi_reg <= ~nib_hi_reg;
        if (!nib_hi_reg) begin
          nib_lo_reg <= pin_s2_reg.d;
        end
      end
    end
  end

  // byte counter, saturates one past the limit so overflow stays visible
  always_ff @(posedge clk_i) begin
    if (rst_i || (rx_edge && state_reg != ERS_DATA)) begin
      frame_byte_counter_reg <= 12'h000;
    end else if (byte_done && frame_byte_counter_reg <= ERS_LEN_LIMIT) begin
      frame_byte_counter_reg <= frame_byte_counter_reg + 12'h001; // RQ13
    end
  end

  // header capture: destination, tag, length/type
  always_ff @(posedge clk_i) begin
    if (rst_i || (rx_edge && state_reg != ERS_DATA)) begin
      dst_reg <= '0;
      tpid_reg <= 16'h0000;
      len_type_reg <= 16'h0000;
      tagged_reg <= 1'b0;
    end else if (byte_done) begin
      if (frame_byte_counter_reg < 12'd6) begin
        dst_reg <= {dst_reg[39:0], byte_now};
      end
      if (frame_byte_counter_reg == 12'd12 || frame_byte_counter_reg == 12'd13) begin
        tpid_reg <= {tpid_reg[7:0], byte_now}; // RQ5
      end
      if (frame_byte_counter_reg == 12'd14) begin
        tagged_reg <= (tpid_reg == ERS_VLAN_TPID); // RQ5
      end
      if (frame_byte_counter_reg == 12'd16 || frame_byte_counter_reg == 12'd17) begin
        len_type_reg <= {len_type_reg[7:0], byte_now}; // RQ5
      end
    end
  end

  // crc accumulation over the whole frame including fcs
  always_ff @(posedge clk_i) begin
    if (rst_i || (rx_edge && state_reg != ERS_DATA)) begin
      crc_reg <= 32'hffff_ffff;
    end else if (byte_done) begin
      crc_reg <= crc_byte(crc_reg, byte_now);
    end
  end

  // per-frame error events
  always_ff @(posedge clk_i) begin
    if (rst_i || (rx_edge && state_reg == ERS_IDLE && pin_s2_reg.dv)) begin
      phy_rx_error_flag_reg <= 1'b0;
      late_collision_flag_reg <= 1'b0;
      early_coll_reg <= 1'b0;
    end else if (rx_edge && state_reg == ERS_DATA && pin_s2_reg.dv) begin
      if (pin_s2_reg.er) begin
        phy_rx_error_flag_reg <= 1'b1; // RQ3
      end
      if (pin_s2_reg.col && frame_byte_counter_reg >= ERS_COLL_WIN) begin
        late_collision_flag_reg <= 1'b1; // RQ7
      end
      if (pin_s2_reg.col && frame_byte_counter_reg < ERS_COLL_WIN) begin
        early_coll_reg <= 1'b1; // RQ9
      end
    end
  end

  // false carrier: rx_er with data 0xe while dv is low; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      false_carrier_flag_reg <= 1'b0;
    end else if (rx_edge && !pin_s2_reg.dv && pin_s2_reg.er && pin_s2_reg.d == 4'he) begin
      false_carrier_flag_reg <= 1'b1; // RQ11
    end else if (frame_done_o) begin
      false_carrier_flag_reg <= 1'b0;
    end
  end

  // end-of-frame evaluation, flags from this frame only, false carrier from the gap since the last reported frame
  logic [15:0] lt_field;
  logic is_runt;
  logic overflow;
  logic crc_bad;
  logic [11:0] max_len;
  logic [31:0] status_next;
  always_comb begin
    lt_field = tagged_reg ? len_type_reg : tpid_reg; // RQ5
    overflow = frame_byte_counter_reg > ERS_LEN_LIMIT; // RQ10
    is_runt = early_coll_reg || frame_byte_counter_reg < ERS_COLL_WIN; // RQ9
    max_len = tagged_reg ? ERS_MAX_TAG : ERS_MAX_UNTAG;
    // runt and overflow frames do not report crc errors
    crc_bad = crc_reg != ERS_CRC_RESIDUE && !is_runt && !overflow; // RQ15
    status_next = ERS_STATUS_RST;
    status_next[ERS_EB_BIT] = nib_hi_reg; // RQ1 RQ2
    status_next[ERS_ME_BIT] = phy_rx_error_flag_reg;
    status_next[ERS_CE_BIT] = crc_bad || phy_rx_error_flag_reg; // RQ16
    status_next[ERS_FT_BIT] = lt_field >= ERS_TYPE_MIN; // RQ4 RQ6
    status_next[ERS_CF_BIT] = lt_field == ERS_CTRL_TYPE; // RQ6
    status_next[ERS_LC_BIT] = late_collision_flag_reg;
    status_next[ERS_OL_BIT] = !crc_bad && !phy_rx_error_flag_reg && !overflow
      && frame_byte_counter_reg > max_len; // RQ8
    status_next[ERS_RF_BIT] = is_runt;
    status_next[ERS_WT_BIT] = overflow; // RQ10 RQ14
    status_next[ERS_FC_BIT] = false_carrier_flag_reg;
    status_next[12:11] = 2'b00; // RQ12
    status_next[10:0] = frame_byte_counter_reg[10:0]; // RQ13
  end

  // status word and frame counter update once per frame
  logic [31:0] rx_frame_status_reg;
  logic [31:0] frame_count_reg;
  logic [31:0] ctrl_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_frame_status_reg <= ERS_STATUS_RST;
      frame_count_reg <= 32'h0000_0000;
      frame_done_o <= 1'b0;
    end else begin
      frame_done_o <= frame_end && ctrl_reg[0];
      if (frame_end && ctrl_reg[0]) begin
        rx_frame_status_reg <= status_next; // RQ17
        frame_count_reg <= frame_count_reg + 32'h0000_0001;
      end
    end
  end

  // wishbone classic slave, ack one cycle after strobe, dropped for a cycle
  logic wb_hit;
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= ERS_CTRL_RST;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit) begin
        unique case (wb_req_i.adr)
          ERS_STATUS_OFS: wb_dat_o <= rx_frame_status_reg;
          ERS_CTRL_OFS: wb_dat_o <= ctrl_reg;
          ERS_COUNT_OFS: wb_dat_o <= frame_count_reg;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
        if (wb_req_i.we && wb_req_i.adr == ERS_CTRL_OFS && wb_req_i.sel[0]) begin
          ctrl_reg[0] <= wb_req_i.dat[0];
        end
      end
    end
  end

  // checks
  wb_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_frame_status_reg[12:11] == 2'b00) else $error("reserved bits set"); // RQ12
  me_forces_ce_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_frame_status_reg[ERS_ME_BIT] |-> rx_frame_status_reg[ERS_CE_BIT])
    else $error("phy error without crc error"); // RQ16
  cf_implies_ft_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_frame_status_reg[ERS_CF_BIT] |-> rx_frame_status_reg[ERS_FT_BIT])
    else $error("control without type flag"); // RQ6
  status_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !frame_done_o |-> $stable(rx_frame_status_reg) or $past(frame_end && ctrl_reg[0]))
    else $error("status changed mid frame"); // RQ17
  er_sets_me_a: assert property (@(posedge clk_i) disable iff (rst_i)
    byte_done && pin_s2_reg.er |=> phy_rx_error_flag_reg)
    else $error("rx error lost"); // RQ3
  wt_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_done_o |-> rx_frame_status_reg[ERS_WT_BIT] == $past(frame_byte_counter_reg > 12'h7ff))
    else $error("overflow flag mismatch"); // RQ10
  ol_not_wt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_frame_status_reg[ERS_OL_BIT] |-> !rx_frame_status_reg[ERS_WT_BIT]
    && rx_frame_status_reg[10:0] > 11'd1518) else $error("oversize flag wrong"); // RQ8
  runt_short_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_done_o && rx_frame_status_reg[10:0] < 11'd64 && !rx_frame_status_reg[ERS_WT_BIT]
    |-> rx_frame_status_reg[ERS_RF_BIT]) else $error("short frame not runt"); // RQ9
  frame_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) frame_done_o);
  runt_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    frame_done_o && rx_frame_status_reg[ERS_RF_BIT]);
  good_frame_c: cover property (@(posedge clk_i) disable iff (rst_i)
    frame_done_o && !rx_frame_status_reg[ERS_CE_BIT] && rx_frame_status_reg[ERS_FT_BIT]);
endmodule // ers_rx_status

// ===== verif/ers_phy_model.sv
// behavioural mii receive side of an ethernet phy, nibble wide
`timescale 1ns/1ps
module ers_phy_model (
  output logic rx_clk_o,
  output ers_pkg::ers_mii_t mii_o
);
  import ers_pkg::*;
  logic [7:0] fb [0:1600];
  // idle pins; the rx clock stands still outside bursts
  initial begin
    rx_clk_o = 1'b0;
    mii_o = '0;
  end
  // one rx clock period, pins change while the clock is low
  task automatic nib(input logic dv, input logic er, input logic col, input logic [3:0] d);
    mii_o = '{dv, er, col, d};
    #80 rx_clk_o = 1'b1;
    #80 rx_clk_o = 1'b0;
  endtask
  // send fb[0..n-1] plus fcs; er_at and col_at are byte indexes, -1 for none
  task automatic frame(input int n, input int er_at, input int col_at, input bit bad,
    input bit odd);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < 8; b++) begin
        c = (c >> 1) ^ ((c[0] ^ fb[i][b]) ? 32'hedb88320 : 32'h0);
      end
    end
    // bad only flips one fcs bit, so the length stays intact
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) fb[n + i] = c[8 * i +: 8];
    for (int i = 0; i < 15; i++) nib(1'b1, 1'b0, 1'b0, 4'h5);
    nib(1'b1, 1'b0, 1'b0, 4'hd);
    for (int i = 0; i < n + 4; i++) begin
      nib(1'b1, i == er_at, i == col_at, fb[i][3:0]);
      nib(1'b1, i == er_at, i == col_at, fb[i][7:4]);
    end
    if (odd) nib(1'b1, 1'b0, 1'b0, 4'ha);
    // released data lines show the inverse of the last nibble
    nib(1'b0, 1'b0, 1'b0, ~mii_o.d);
  endtask
  // false carrier burst between frames
  task automatic fc();
    repeat (4) nib(1'b0, 1'b1, 1'b0, 4'he);
    nib(1'b0, 1'b0, 1'b0, 4'h1);
  endtask
endmodule // ers_phy_model

// ===== verif/ers_rx_status_tb.sv
// self-checking bench for the receive frame status block
`timescale 1ns/1ps
module ers_rx_status_tb;
  import ers_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_clk;
  ers_mii_t mii;
  ers_wb_req_t req = '0;
  logic [31:0] rd;
  logic ack, done;
  logic seen = 1'b0;
  bit en = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int tno = 0;
  // 100 mhz system clock
  always #5 clk_i = ~clk_i;
  ers_rx_status i_dut (.clk_i(clk_i), .rst_i(rst_i), .mii_rx_clk_i(rx_clk), .mii_i(mii),
    .wb_req_i(req), .wb_dat_o(rd), .wb_ack_o(ack), .frame_done_o(done));
  ers_phy_model i_phy (.rx_clk_o(rx_clk), .mii_o(mii));
  // done is a one-cycle pulse, so latch it; the cycle ceiling cuts hangs short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (done === 1'b1) seen <= 1'b1;
    if (cycles == 99000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rd;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  function automatic logic [31:0] f(input int b);
    return 32'h1 << b;
  endfunction
  // one frame through the phy, then status compared whole, length included
  task automatic run(input int n, input logic [15:0] typ, input bit tag, input int er_at,
    input int col_at, input bit bad, input bit odd, input logic [31:0] fl);
    for (int i = 0; i < n; i++) i_phy.fb[i] = 8'(i + 3);
    i_phy.fb[12] = tag ? 8'h81 : typ[15:8];
    i_phy.fb[13] = tag ? 8'h00 : typ[7:0];
    i_phy.fb[16] = typ[15:8];
    i_phy.fb[17] = typ[7:0];
    seen <= 1'b0;
    i_phy.frame(n, er_at, col_at, bad, odd);
    @(posedge clk_i);
    repeat (40) if (seen !== 1'b1) @(posedge clk_i);
    chk({31'h0, seen}, {31'h0, en});
    rdchk(ERS_STATUS_OFS, en ? (fl | 32'(n + 4)) : 32'h0);
    tno++;
    $display("frame test %0d done", tno);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence; a disabled receiver must ignore the first frame
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(ERS_STATUS_OFS, ERS_STATUS_RST);
    rdchk(ERS_CTRL_OFS, ERS_CTRL_RST);
    rdchk(8'h0c, 32'h0);
    run(60, 16'h0800, 0, -1, -1, 0, 0, 0);
    wb(1'b1, ERS_CTRL_OFS, 32'h1, q);
    wb(1'b1, ERS_STATUS_OFS, 32'hffffffff, q);
    rdchk(ERS_CTRL_OFS, 32'h1);
    rdchk(ERS_STATUS_OFS, 32'h0);
    en = 1'b1;
    run(60, 16'h05ff, 0, -1, -1, 0, 0, 0);
    run(60, 16'h0600, 0, -1, -1, 0, 0, f(ERS_FT_BIT));
    run(60, 16'h05dc, 1, -1, -1, 0, 0, 0);
    run(60, 16'h0800, 1, -1, -1, 0, 0, f(ERS_FT_BIT));
    run(60, 16'h8808, 0, -1, -1, 0, 0, f(ERS_FT_BIT) | f(ERS_CF_BIT));
    run(60, 16'h0800, 0, -1, -1, 0, 1, f(ERS_FT_BIT) | f(ERS_EB_BIT));
    run(60, 16'h0800, 0, 20, -1, 0, 0, f(ERS_FT_BIT) | f(ERS_ME_BIT) | f(ERS_CE_BIT));
    run(60, 16'h0800, 0, -1, -1, 1, 0, f(ERS_FT_BIT) | f(ERS_CE_BIT));
    run(96, 16'h0800, 0, -1, 63, 0, 0, f(ERS_FT_BIT) | f(ERS_RF_BIT));
    run(96, 16'h0800, 0, -1, 64, 0, 0, f(ERS_FT_BIT) | f(ERS_LC_BIT));
    run(36, 16'h0800, 0, -1, -1, 0, 0, f(ERS_FT_BIT) | f(ERS_RF_BIT));
    i_phy.fc();
    run(60, 16'h0800, 0, -1, -1, 0, 0, f(ERS_FT_BIT) | f(ERS_FC_BIT));
    run(1515, 16'h0800, 0, -1, -1, 0, 0, f(ERS_FT_BIT) | f(ERS_OL_BIT));
    rdchk(ERS_COUNT_OFS, 32'h0000_000d);
    wrap_up();
  end
endmodule // ers_rx_status_tb
